// File: shared/pcd_pkg.sv
/*
 * Package for the clock configuration word decoder.
 * Holds field positions, reset values, the register map of the decoder's
 * Wishbone slave and the struct that carries decoded settings.
 * Assumes a 32-bit classic Wishbone bus and a 20 MHz system clock.
 */
package pcd_pkg;

    // =========================================================
    // Configuration word fields
    // =========================================================
    localparam int MAIN_OUT_DIV_LSB = 16;
    localparam int USB_BYPASS_BIT = 15;
    localparam int USB_IN_DIV_LSB = 8;
    localparam int MAIN_MULT_LSB = 4;
    localparam int MAIN_IN_DIV_LSB = 0;
    localparam int SEL_W = 3;
    localparam logic [31:0] RESERVED_MASK = 32'hFFF8_7888;
    localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

    // =========================================================
    // Register map (byte addresses)
    // =========================================================
    localparam logic [3:0] ADDR_CFG_WORD = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_DECODED = 4'hC;
    localparam int CTRL_RELOAD_BIT = 0;
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_RSVD_BIT = 1;
    localparam int STAT_MULT_BAD_BIT = 2;

    // =========================================================
    // Carriers
    // =========================================================
    typedef struct packed {
        logic [8:0] main_out_ratio;
        logic usb_pll_run;
        logic [3:0] usb_in_ratio;
        logic [4:0] main_mult;
        logic [2:0] main_pll_in_div_sel;
    } pcd_pll_cfg_s;

    typedef enum logic [1:0] {
        PCD_IDLE,
        PCD_LOAD,
        PCD_HOLD
    } pcd_state_e;

endpackage : pcd_pkg

// File: design/pcd_field_decode.sv
/*
 * Combinational decode of the configuration word into PLL settings.
 * Assumes the word is stable while its outputs are sampled.
 */
`timescale 1ns/1ps
module pcd_field_decode
    import pcd_pkg::*;
(
    input wire logic [31:0] cfg_word,
    output pcd_pll_cfg_s pll_cfg,
    output logic rsvd_bad,
    output logic mult_bad
);

    // =========================================================
    // Ratio tables
    // =========================================================
    function automatic logic [8:0] out_ratio(input logic [2:0] sel);
        logic [8:0] r;
        r = 9'h001;
        case (sel)
            3'h7: r = 9'h100;
            default: r = 9'(9'h001 << sel);
        endcase
        return r;
    endfunction : out_ratio

    function automatic logic [3:0] usb_ratio(input logic [2:0] sel);
        logic [3:0] r;
        r = 4'h1;
        case (sel)
            3'h6: r = 4'hA;
            3'h7: r = 4'hC;
            default: r = 4'(sel + 3'h1);
        endcase
        return r;
    endfunction : usb_ratio

    function automatic logic [4:0] mult_factor(input logic [2:0] sel);
        logic [4:0] r;
        r = 5'h00;
        case (sel)
            3'h0: r = 5'h00;
            3'h7: r = 5'h18;
            default: r = 5'(5'h0F + sel);
        endcase
        return r;
    endfunction : mult_factor

    always_comb begin
        pll_cfg.main_out_ratio = out_ratio(cfg_word[MAIN_OUT_DIV_LSB +: SEL_W]);
        pll_cfg.usb_pll_run = ~cfg_word[USB_BYPASS_BIT];
        pll_cfg.usb_in_ratio = usb_ratio(cfg_word[USB_IN_DIV_LSB +: SEL_W]);
        pll_cfg.main_mult = mult_factor(cfg_word[MAIN_MULT_LSB +: SEL_W]);
        pll_cfg.main_pll_in_div_sel = cfg_word[MAIN_IN_DIV_LSB +: SEL_W];
        rsvd_bad = (cfg_word & RESERVED_MASK) != RESERVED_MASK;
        mult_bad = cfg_word[MAIN_MULT_LSB +: SEL_W] == 3'h0;
    end

endmodule : pcd_field_decode

// File: design/pcd_cfg_decoder.sv
/*
 * Top of the clock configuration word decoder.
 * Captures the non-volatile word once after reset (and on software reload),
 * decodes it and holds the PLL settings for the clock generator. A classic
 * Wishbone slave exposes the word, status and decoded values.
 * Assumes nvm_word comes from another domain and is stable after power-up.
 */
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Output divider codes give 1 to 256
// - Bit 15 set bypasses USB PLL
// - USB input divider codes give 1 to 12
// - Multiplier codes 001-111 give 16 to 24
module pcd_cfg_decoder
    import pcd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] nvm_word,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output pcd_pll_cfg_s pll_cfg_o,
    output logic cfg_valid_o
);

    // =========================================================
    // Input synchroniser
    // =========================================================
    logic [31:0] word_meta_r;
    logic [31:0] word_sync_r;

    // The synchroniser runs through reset, so the first load after release
    // captures the settled pin word instead of an erased value.
    always_ff @(posedge clk) begin
        word_meta_r <= nvm_word;
        word_sync_r <= word_meta_r;
    end

    // =========================================================
    // Load sequencer
    // =========================================================
    pcd_state_e state_r;
    pcd_state_e state_nxt;
    logic [31:0] cfg_word_r;
    logic reload_req;
    logic [31:0] dec_word;
    pcd_pll_cfg_s dec_cfg;
    logic dec_rsvd_bad;
    logic dec_mult_bad;
    logic rsvd_bad_r;
    logic mult_bad_r;

    // The load waits one cycle so the synchroniser holds a settled word.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PCD_IDLE: state_nxt = PCD_LOAD;
            PCD_LOAD: state_nxt = PCD_HOLD;
            PCD_HOLD: begin
                if (reload_req) begin
                    state_nxt = PCD_LOAD;
                end
            end
            default: state_nxt = PCD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= PCD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_word_r <= ERASED_WORD;
        end else if (state_r == PCD_LOAD) begin
            cfg_word_r <= word_sync_r;
        end
    end

    assign dec_word = cfg_word_r;

    pcd_field_decode u_decode (
        .cfg_word(dec_word),
        .pll_cfg(dec_cfg),
        .rsvd_bad(dec_rsvd_bad),
        .mult_bad(dec_mult_bad)
    );

    // Settings are only presented once a captured word has been decoded.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pll_cfg_o <= '0;
            cfg_valid_o <= 1'b0;
            rsvd_bad_r <= 1'b0;
            mult_bad_r <= 1'b0;
        end else if (state_r == PCD_HOLD) begin
            pll_cfg_o <= dec_cfg;
            cfg_valid_o <= 1'b1;
            rsvd_bad_r <= dec_rsvd_bad;
            mult_bad_r <= dec_mult_bad;
        end else begin
            cfg_valid_o <= 1'b0;
        end
    end

    // =========================================================
    // Wishbone slave
    // =========================================================
    logic bus_req;
    logic adr_ok;
    logic [31:0] rd_data;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign adr_ok = (wb_adr_i == ADDR_CFG_WORD) || (wb_adr_i == ADDR_CTRL)
        || (wb_adr_i == ADDR_STATUS) || (wb_adr_i == ADDR_DECODED);
    assign reload_req = bus_req && wb_we_i && (wb_adr_i == ADDR_CTRL)
        && wb_sel_i[0] && wb_dat_i[CTRL_RELOAD_BIT];

    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_CFG_WORD: rd_data = cfg_word_r;
            ADDR_STATUS: begin
                rd_data[STAT_VALID_BIT] = cfg_valid_o;
                rd_data[STAT_RSVD_BIT] = rsvd_bad_r;
                rd_data[STAT_MULT_BAD_BIT] = mult_bad_r;
            end
            ADDR_DECODED: rd_data = 32'(pll_cfg_o);
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && adr_ok;
            wb_err_o <= bus_req && !adr_ok;
            wb_dat_o <= (bus_req && adr_ok && !wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    chk_out_div_top: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o && cfg_word_r[18:16] == 3'h7 |-> pll_cfg_o.main_out_ratio == 9'h100)
        else $error("Output divider code 7 not decoded to 256.");
    chk_out_div_pow: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o && cfg_word_r[18:16] != 3'h7
        |-> $onehot(pll_cfg_o.main_out_ratio) && pll_cfg_o.main_out_ratio[cfg_word_r[18:16]])
        else $error("Output divider ratio wrong.");
    chk_usb_bypass: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o |-> pll_cfg_o.usb_pll_run == !cfg_word_r[15])
        else $error("USB PLL bypass does not follow bit 15.");
    chk_usb_div_hi: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o && cfg_word_r[10:9] == 2'h3
        |-> pll_cfg_o.usb_in_ratio == (cfg_word_r[8] ? 4'hC : 4'hA))
        else $error("USB divider high codes wrong.");
    chk_usb_div_lo: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o && cfg_word_r[10:9] != 2'h3
        |-> pll_cfg_o.usb_in_ratio == 4'(cfg_word_r[10:8] + 3'h1))
        else $error("USB divider low codes wrong.");
    chk_mult_factor: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o && cfg_word_r[6:4] == 3'h7 |-> pll_cfg_o.main_mult == 5'h18)
        else $error("Multiplier code 7 not 24.");
    chk_mult_range: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o && cfg_word_r[6:4] inside {[3'h1:3'h6]}
        |-> pll_cfg_o.main_mult == 5'(5'h0F + cfg_word_r[6:4]))
        else $error("Multiplier codes 1 to 6 wrong.");
    chk_mult_zero: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o && cfg_word_r[6:4] == 3'h0 |-> pll_cfg_o.main_mult == 5'h00 && mult_bad_r)
        else $error("Multiplier code 0 not flagged.");
    chk_in_div_pass: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o |-> pll_cfg_o.main_pll_in_div_sel == cfg_word_r[2:0])
        else $error("Main input divider not passed through.");
    chk_rsvd_flag: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o |-> rsvd_bad_r == ((cfg_word_r & RESERVED_MASK) != RESERVED_MASK))
        else $error("Reserved-bit flag wrong.");
    chk_bus_ack: assert property (@(posedge clk) disable iff (!rst_b)
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("Bus request not answered in one cycle.");
    chk_ack_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge held longer than one cycle.");
    chk_err_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        wb_err_o |=> !wb_err_o)
        else $error("Error response held longer than one cycle.");
    chk_resp_excl: assert property (@(posedge clk) disable iff (!rst_b)
        !(wb_ack_o && wb_err_o))
        else $error("Acknowledge and error given together.");
    chk_dat_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("Read data not zero outside an acknowledge.");
    chk_load_capture: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == PCD_LOAD |=> cfg_word_r == $past(word_sync_r))
        else $error("Captured word differs from synchronised word.");
    chk_load_valid: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == PCD_LOAD |=> !cfg_valid_o ##1 cfg_valid_o)
        else $error("Settings not presented after a load.");
    // The valid flag stays up while the reload write is answered, then drops
    // for the single cycle after the load cycle before the new settings appear.
    chk_reload_seq: assert property (@(posedge clk) disable iff (!rst_b)
        reload_req && state_r == PCD_HOLD |=> cfg_valid_o ##1 !cfg_valid_o ##1 cfg_valid_o)
        else $error("Reload sequence timing wrong.");

    cov_usb_bypass: cover property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o && !pll_cfg_o.usb_pll_run);
    cov_div_256: cover property (@(posedge clk) disable iff (!rst_b)
        cfg_valid_o && pll_cfg_o.main_out_ratio == 9'h100);
    cov_reload: cover property (@(posedge clk) disable iff (!rst_b) reload_req);
    cov_unmapped: cover property (@(posedge clk) disable iff (!rst_b) wb_err_o);

endmodule : pcd_cfg_decoder

// File: sim/pcd_cfg_decoder_test.sv
/* Self-checking bench for the clock configuration word decoder.
   Assumes pcd_pkg is compiled first and drives every port of the top itself. */
`timescale 1ns/1ps
module pcd_cfg_decoder_test
    import pcd_pkg::*;
;
    // =========================================================
    // Signals and design
    // =========================================================
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] nvm_word = 32'hFFF8_F888;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic cfg_valid_o;
    pcd_pll_cfg_s pll_cfg_o;
    int err_count = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    logic [31:0] seed = 32'h0000_504F;
    localparam logic [8:0] ODIV [8] = '{9'h1, 9'h2, 9'h4, 9'h8, 9'h10, 9'h20, 9'h40, 9'h100};
    localparam logic [3:0] UDIV [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};
    localparam logic [4:0] MULT [8] = '{5'h0, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};

    pcd_cfg_decoder dut (
        .clk(clk), .rst_b(rst_b), .nvm_word(nvm_word),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .pll_cfg_o(pll_cfg_o), .cfg_valid_o(cfg_valid_o)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic pcd_pll_cfg_s exp_cfg(logic [31:0] w);
        pcd_pll_cfg_s c;
        c.main_out_ratio = ODIV[w[18:16]];
        c.usb_pll_run = ~w[15];
        c.usb_in_ratio = UDIV[w[10:8]];
        c.main_mult = MULT[w[6:4]];
        c.main_pll_in_div_sel = w[2:0];
        return c;
    endfunction : exp_cfg

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("Checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // One classic cycle; ends at the edge where ack or err is sampled high.
    task automatic wb_xfer(logic we, logic [3:0] adr, logic [31:0] dat,
                           output logic [31:0] rd, output logic er);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic verify(logic [31:0] w);
        logic [31:0] rd;
        logic er;
        pcd_pll_cfg_s e;
        e = exp_cfg(w);
        check("valid", {31'h0, cfg_valid_o}, 32'h1);
        check("pll_cfg", {10'h0, pll_cfg_o}, {10'h0, e});
        wb_xfer(1'b0, ADDR_DECODED, 32'h0, rd, er);
        check("decoded", rd, {10'h0, e});
        wb_xfer(1'b0, ADDR_STATUS, 32'h0, rd, er);
        check("status", rd,
              {29'h0, w[6:4] == 3'h0, (w & RESERVED_MASK) != RESERVED_MASK, 1'b1});
        wb_xfer(1'b0, ADDR_CFG_WORD, 32'h0, rd, er);
        check("cfg_word", rd, w);
    endtask : verify

    task automatic apply(logic [31:0] w);
        logic [31:0] rd;
        logic er;
        nvm_word <= w;
        repeat (4) @(posedge clk);
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_0001, rd, er);
        // Valid is low for the one cycle after the load cycle, the cycle that follows the acknowledge.
        @(posedge clk);
        check("valid_drop", {31'h0, cfg_valid_o}, 32'h0);
        repeat (2) @(posedge clk);
        verify(w);
    endtask : apply

    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            err_count++;
            close_out();
        end
    end

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        logic [31:0] rd;
        logic er;
        logic [31:0] w;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        verify(nvm_word);
        $display("Test reset_decode done");
        for (int i = 0; i < 8; i++) begin
            w = rnd() | RESERVED_MASK;
            w[18:16] = i[2:0];
            w[15] = i[0];
            w[10:8] = 3'h7 - i[2:0];
            w[6:4] = i[2:0] + 3'h3;
            apply(w);
        end
        $display("Test code_table done");
        for (int i = 0; i < 6; i++) begin
            w = rnd();
            apply(w);
        end
        $display("Test random_words done");
        wb_xfer(1'b0, 4'h2, 32'h0, rd, er);
        check("unmapped_err", {31'h0, er}, 32'h1);
        wb_xfer(1'b1, ADDR_CFG_WORD, ~w, rd, er);
        wb_xfer(1'b0, ADDR_CFG_WORD, 32'h0, rd, er);
        check("cfg_read_only", rd, w);
        wb_xfer(1'b0, ADDR_CTRL, 32'h0, rd, er);
        check("ctrl_read", rd, 32'h0);
        $display("Test bus_access done");
        close_out();
    end
endmodule : pcd_cfg_decoder_test
